// [ptm_axil_slave.v]
// AXI4-Lite slave front end producing single-cycle register strobes.
`timescale 1ns/1ns
module ptm_axil_slave (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         wr_en,
  output reg  [11:0] wr_addr,
  output reg  [7:0]  wr_data,
  output reg         rd_en,
  output reg  [11:0] rd_addr,
  input  wire [7:0]  rd_data,
  input  wire        rd_ok,
  input  wire        wr_ok
);

  reg        aw_have;
  reg        w_have;
  reg        w_lane;
  reg        rd_wait;

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      w_lane        <= 1'b0;
      wr_en         <= 1'b0;
      wr_addr       <= 12'h000;
      wr_data       <= 8'h00;
      rd_en         <= 1'b0;
      rd_addr       <= 12'h000;
      rd_wait       <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      wr_en         <= 1'b0;
      rd_en         <= 1'b0;
      // Address and data are taken independently, in either order.
      if (s_axi_awvalid && !aw_have && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_have       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_have       <= 1'b1;
        w_lane       <= s_axi_wstrb[0];
        wr_data      <= s_axi_wdata[7:0];
      end
      if (aw_have && w_have && !wr_en && !s_axi_bvalid) begin
        // Only byte lane 0 carries register bits; other lanes are ignored.
        wr_en        <= w_lane;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !rd_wait && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        rd_addr       <= s_axi_araddr;
        rd_wait       <= 1'b1;
      end
      if (rd_wait && !s_axi_arready) begin
        rd_en        <= 1'b1;
        rd_wait      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_data};
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ptm_axil_slave

// [ptm_clock_select.v]
// Counter tick generator: divided internal rates and external pin edges.
`timescale 1ns/1ns
`include "ptm_defines.vh"
module ptm_clock_select #(
  parameter SUB_DIV = `PTM_DIV_SUB
) (
  input  wire       clk_sys,
  input  wire       srst,
  input  wire [2:0] clk_sel,
  input  wire       ext_pin,
  output reg        tick,
  output reg        ext_rise,
  output reg        ext_fall
);

  reg [6:0] div_reg;
  reg [6:0] sub_reg;
  reg       ext_reg;

  always @(posedge clk_sys) begin
    if (srst) begin
      div_reg  <= 7'h00;
      sub_reg  <= 7'h00;
      ext_reg  <= 1'b0;
      tick     <= 1'b0;
      ext_rise <= 1'b0;
      ext_fall <= 1'b0;
    end else begin
      div_reg  <= div_reg + 7'h01;
      sub_reg  <= (sub_reg == SUB_DIV - 1) ? 7'h00 : sub_reg + 7'h01;
      ext_reg  <= ext_pin;
      ext_rise <= ext_pin & ~ext_reg;
      ext_fall <= ~ext_pin & ext_reg;
      case (clk_sel)
        `PTM_CK_SYS4:     tick <= (div_reg[1:0] == 2'h3);
        `PTM_CK_SYS:      tick <= 1'b1;
        `PTM_CK_H16:      tick <= (div_reg[3:0] == 4'hf);
        `PTM_CK_H64:      tick <= (div_reg[5:0] == 6'h3f);
        `PTM_CK_SUB0,
        `PTM_CK_SUB1:     tick <= (sub_reg == SUB_DIV - 1);
        `PTM_CK_EXT_RISE: tick <= ext_pin & ~ext_reg;
        `PTM_CK_EXT_FALL: tick <= ~ext_pin & ext_reg;
        default:          tick <= 1'b0;
      endcase
    end
  end

endmodule // ptm_clock_select

// [ptm_defines.vh]
// Register offsets, field positions, reset values and timing constants of the periodic timer.
`ifndef PTM_DEFINES_VH
`define PTM_DEFINES_VH

`define PTM_OFF_DUTY_LO     12'h000
`define PTM_OFF_DUTY_HI     12'h004
`define PTM_OFF_PERIOD_LO   12'h008
`define PTM_OFF_PERIOD_HI   12'h00c
`define PTM_OFF_CTRL0       12'h010
`define PTM_OFF_CTRL1       12'h014
`define PTM_OFF_COUNT_LO    12'h018
`define PTM_OFF_COUNT_HI    12'h01c
`define PTM_OFF_FLAGS       12'h020

`define PTM_RST_BYTE        8'h00

`define PTM_C0_PAUSE        7
`define PTM_C0_CKSEL_HI     6
`define PTM_C0_CKSEL_LO     4
`define PTM_C0_ON           3
`define PTM_C1_MODE_HI      7
`define PTM_C1_MODE_LO      6
`define PTM_C1_PIN_HI       5
`define PTM_C1_PIN_LO       4
`define PTM_C1_OC           3
`define PTM_C1_POL          2
`define PTM_C1_CCLR         0
`define PTM_FL_A            0
`define PTM_FL_P            1

`define PTM_MODE_CMP        2'b00
`define PTM_MODE_PWM        2'b10
`define PTM_MODE_TC         2'b11
`define PTM_PIN_NONE        2'b00
`define PTM_PIN_LOW         2'b01
`define PTM_PIN_HIGH        2'b10
`define PTM_PIN_TOGGLE      2'b11

`define PTM_CK_SYS4         3'b000
`define PTM_CK_SYS          3'b001
`define PTM_CK_H16          3'b010
`define PTM_CK_H64          3'b011
`define PTM_CK_SUB0         3'b100
`define PTM_CK_SUB1         3'b101
`define PTM_CK_EXT_RISE     3'b110
`define PTM_CK_EXT_FALL     3'b111

`define PTM_DIV_SYS4        4
`define PTM_DIV_H16         16
`define PTM_DIV_H64         64
`define PTM_DIV_SUB         32

`define PTM_CNT_MAX         10'h3ff

`endif

// [ptm_periodic_timer.v]
// Periodic 10-bit timer with compare, timer/counter, PWM and single-pulse modes.
// Operation
// - Two-bit mode field selects four modes; code decodes three, single pulse is PWM with toggle pin field.
// - Clear-select low: clear on P match or overflow.
// - Clear-select high: clear on A, no P flag.
// - Compare A zero: overflow at 3FF, no A flag.
// - Compare mode pin changes only on A match.
// - A match sets, clears or toggles pin.
// - Timer-on rise loads pin initial level.
// - Timer/counter mode like compare, pin undriven.
// - PWM period from P match, clear-select ignored.
// - Period zero gives 1024 clocks.
// - Duty at or above period gives full duty.
// - PWM flags on A and P matches.
// - Output-control sets polarity, pin field forces.
// - PWM counting continues while pin forced.
// - Timer-on rise starts pulse and counter.
// - External pin edge sets timer-on bit.
// - A match ends pulse, clears timer-on.
// - Single pulse ignores period and clear-select.
// - Timer-on rise zeroes counter, fall holds.
// - Three-bit field selects counter clock.
// - Pause bit freezes and resumes counter.
// - Polarity bit inverts driven pin level.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "ptm_defines.vh"
module ptm_periodic_timer #(
  parameter CNT_W   = 10,
  parameter SUB_DIV = `PTM_DIV_SUB
) (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_clock_trigger_pin,
  output reg         timer_output_pin,
  output reg         timer_output_pin_oe,
  output reg         a_match_flag,
  output reg         p_match_flag
);

  wire        wr_en;
  wire [11:0] wr_addr;
  wire [7:0]  wr_data;
  wire        rd_en;
  wire [11:0] rd_addr;
  reg  [7:0]  rd_data;
  reg         rd_ok;
  reg         wr_ok;
  wire        tick;
  wire        ext_rise;
  wire        ext_fall;

  reg  [7:0]       duty_compare_low_reg;
  reg  [1:0]       duty_compare_high_reg;
  reg  [7:0]       period_compare_low_reg;
  reg  [1:0]       period_compare_high_reg;
  reg              pause_bit_reg;
  reg  [2:0]       clock_select_field_reg;
  reg              timer_on_bit_reg;
  reg  [1:0]       mode_field_reg;
  reg  [1:0]       pin_function_field_reg;
  reg              output_control_bit_reg;
  reg              output_polarity_bit_reg;
  reg              reserved_bit_reg;
  reg              clear_select_bit_reg;
  reg              on_prev_reg;
  reg  [CNT_W-1:0] count_reg;
  reg  [CNT_W-1:0] count_next;
  reg              level_reg;
  reg              level_next;
  reg              pwm_reg;
  reg              on_next;
  reg              a_hit;
  reg              p_hit;
  reg              set_a;
  reg              set_p;
  reg              pin_next;
  reg              oe_next;

  wire [CNT_W-1:0] compare_a_value = {duty_compare_high_reg, duty_compare_low_reg};
  wire [CNT_W-1:0] period_value    = {period_compare_high_reg, period_compare_low_reg};
  wire             is_cmp  = (mode_field_reg == `PTM_MODE_CMP) ||
                             (mode_field_reg == `PTM_MODE_TC);
  wire             is_pwm  = (mode_field_reg == `PTM_MODE_PWM);
  wire             is_sp   = is_pwm && (pin_function_field_reg == `PTM_PIN_TOGGLE);
  wire             on_rise = timer_on_bit_reg & ~on_prev_reg;
  wire             run     = timer_on_bit_reg & ~pause_bit_reg & tick;
  wire             trig    = (clock_select_field_reg == `PTM_CK_EXT_FALL) ? ext_fall : ext_rise;
  wire [CNT_W-1:0] cnt_inc = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};

  ptm_axil_slave u_bus (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok),
    .wr_ok         (wr_ok)
  );

  ptm_clock_select #(
    .SUB_DIV (SUB_DIV)
  ) u_clk (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .clk_sel  (clock_select_field_reg),
    .ext_pin  (ext_clock_trigger_pin),
    .tick     (tick),
    .ext_rise (ext_rise),
    .ext_fall (ext_fall)
  );

  // Read mux; counter and flag registers show the block's live state.
  always @* begin
    rd_ok = 1'b1;
    case (rd_addr)
      `PTM_OFF_DUTY_LO:   rd_data = duty_compare_low_reg;
      `PTM_OFF_DUTY_HI:   rd_data = {6'h00, duty_compare_high_reg};
      `PTM_OFF_PERIOD_LO: rd_data = period_compare_low_reg;
      `PTM_OFF_PERIOD_HI: rd_data = {6'h00, period_compare_high_reg};
      `PTM_OFF_CTRL0:     rd_data = {pause_bit_reg, clock_select_field_reg,
                                     timer_on_bit_reg, 3'h0};
      `PTM_OFF_CTRL1:     rd_data = {mode_field_reg, pin_function_field_reg,
                                     output_control_bit_reg, output_polarity_bit_reg,
                                     reserved_bit_reg, clear_select_bit_reg};
      `PTM_OFF_COUNT_LO:  rd_data = count_reg[7:0];
      `PTM_OFF_COUNT_HI:  rd_data = {6'h00, count_reg[9:8]};
      `PTM_OFF_FLAGS:     rd_data = {6'h00, p_match_flag, a_match_flag};
      default: begin
        rd_data = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always @* begin
    case (wr_addr)
      `PTM_OFF_DUTY_LO, `PTM_OFF_DUTY_HI, `PTM_OFF_PERIOD_LO, `PTM_OFF_PERIOD_HI,
      `PTM_OFF_CTRL0, `PTM_OFF_CTRL1, `PTM_OFF_FLAGS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Counter, matches, timer-on control and pin level.
  always @* begin
    count_next = count_reg;
    level_next = level_reg;
    on_next    = timer_on_bit_reg;
    a_hit      = 1'b0;
    p_hit      = 1'b0;
    set_a      = 1'b0;
    set_p      = 1'b0;
    if (is_sp && !timer_on_bit_reg && trig) begin
      on_next = 1'b1;
    end
    if (on_rise) begin
      count_next = {CNT_W{1'b0}};
      level_next = output_control_bit_reg;
    end else if (run) begin
      count_next = cnt_inc;
      a_hit      = (cnt_inc == compare_a_value);
      p_hit      = (cnt_inc == period_value);
      if (is_sp) begin
        if (a_hit) begin
          set_a   = 1'b1;
          on_next = 1'b0;
        end
      end else if (is_pwm) begin
        set_a = a_hit;
        set_p = p_hit;
        if (p_hit) begin
          count_next = {CNT_W{1'b0}};
        end
      end else if (is_cmp) begin
        if (clear_select_bit_reg) begin
          set_a = a_hit && (compare_a_value != {CNT_W{1'b0}});
          if (set_a) begin
            count_next = {CNT_W{1'b0}};
          end
        end else begin
          set_a = a_hit && (compare_a_value != {CNT_W{1'b0}});
          set_p = p_hit;
          if (p_hit) begin
            count_next = {CNT_W{1'b0}};
          end
        end
        if (set_a) begin
          case (pin_function_field_reg)
            `PTM_PIN_LOW:    level_next = 1'b0;
            `PTM_PIN_HIGH:   level_next = 1'b1;
            `PTM_PIN_TOGGLE: level_next = ~level_reg;
            default:         level_next = level_reg;
          endcase
        end
      end
    end
  end

  // PWM waveform, polarity and forcing applied to the pin.
  always @* begin
    pin_next = 1'b0;
    oe_next  = 1'b1;
    if (mode_field_reg == `PTM_MODE_TC) begin
      oe_next = 1'b0;
    end else if (is_pwm) begin
      case (pin_function_field_reg)
        `PTM_PIN_NONE:   pin_next = ~output_control_bit_reg;
        `PTM_PIN_LOW:    pin_next = output_control_bit_reg;
        `PTM_PIN_HIGH:   pin_next = pwm_reg ? output_control_bit_reg : ~output_control_bit_reg;
        default:         pin_next = timer_on_bit_reg ? output_control_bit_reg :
                                                       ~output_control_bit_reg;
      endcase
      pin_next = pin_next ^ output_polarity_bit_reg;
    end else begin
      pin_next = level_reg ^ output_polarity_bit_reg;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      duty_compare_low_reg    <= `PTM_RST_BYTE;
      duty_compare_high_reg   <= 2'b00;
      period_compare_low_reg  <= `PTM_RST_BYTE;
      period_compare_high_reg <= 2'b00;
      pause_bit_reg           <= 1'b0;
      clock_select_field_reg  <= 3'b000;
      timer_on_bit_reg        <= 1'b0;
      mode_field_reg          <= 2'b00;
      pin_function_field_reg  <= 2'b00;
      output_control_bit_reg  <= 1'b0;
      output_polarity_bit_reg <= 1'b0;
      reserved_bit_reg        <= 1'b0;
      clear_select_bit_reg    <= 1'b0;
      on_prev_reg             <= 1'b0;
      count_reg               <= {CNT_W{1'b0}};
      level_reg               <= 1'b0;
      pwm_reg                 <= 1'b0;
      a_match_flag            <= 1'b0;
      p_match_flag            <= 1'b0;
      timer_output_pin        <= 1'b0;
      timer_output_pin_oe     <= 1'b0;
    end else begin
      on_prev_reg         <= timer_on_bit_reg;
      count_reg           <= count_next;
      level_reg           <= level_next;
      timer_output_pin    <= pin_next;
      timer_output_pin_oe <= oe_next;
      // full duty when duty not below period
      if (on_rise || (run && set_p)) begin
        pwm_reg <= (compare_a_value != {CNT_W{1'b0}});
      end else if (set_a && (period_value == {CNT_W{1'b0}} || compare_a_value < period_value)) begin
        pwm_reg <= 1'b0;
      end
      timer_on_bit_reg <= on_next;
      if (wr_en) begin
        case (wr_addr)
          `PTM_OFF_DUTY_LO:   duty_compare_low_reg    <= wr_data;
          `PTM_OFF_DUTY_HI:   duty_compare_high_reg   <= wr_data[1:0];
          `PTM_OFF_PERIOD_LO: period_compare_low_reg  <= wr_data;
          `PTM_OFF_PERIOD_HI: period_compare_high_reg <= wr_data[1:0];
          `PTM_OFF_CTRL0: begin
            pause_bit_reg          <= wr_data[`PTM_C0_PAUSE];
            clock_select_field_reg <= wr_data[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO];
            // software start; A-match clear wins over a same-cycle write.
            timer_on_bit_reg       <= wr_data[`PTM_C0_ON] & on_next | wr_data[`PTM_C0_ON] &
                                      ~(is_sp & set_a);
          end
          `PTM_OFF_CTRL1: begin
            mode_field_reg          <= wr_data[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
            pin_function_field_reg  <= wr_data[`PTM_C1_PIN_HI:`PTM_C1_PIN_LO];
            output_control_bit_reg  <= wr_data[`PTM_C1_OC];
            output_polarity_bit_reg <= wr_data[`PTM_C1_POL];
            reserved_bit_reg        <= wr_data[1];
            clear_select_bit_reg    <= wr_data[`PTM_C1_CCLR];
          end
          default: begin
          end
        endcase
      end
      // Write-one-to-clear; a new match in the same cycle keeps the flag set.
      a_match_flag <= set_a | (a_match_flag & ~(wr_en && wr_addr == `PTM_OFF_FLAGS &&
                                                 wr_data[`PTM_FL_A]));
      p_match_flag <= set_p | (p_match_flag & ~(wr_en && wr_addr == `PTM_OFF_FLAGS &&
                                                 wr_data[`PTM_FL_P]));
    end
  end

endmodule // ptm_periodic_timer

// [ptm_periodic_timer_asserts.sv]
// Concurrent checks on the periodic timer's bus and flag ports.
`timescale 1ns/1ns
module ptm_periodic_timer_asserts (
  input wire        clk_sys,
  input wire        srst,
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        a_match_flag,
  input wire        p_match_flag,
  input wire        timer_output_pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire       clr_req = s_axi_awvalid && s_axi_wvalid && s_axi_awaddr == 12'h020;
  reg  [2:0] clr_a_reg;
  reg  [2:0] clr_p_reg;
  // The clear lands a few cycles after it is offered, so a short window stays open.
  always @(posedge clk_sys) begin
    if (srst) begin
      clr_a_reg <= 3'h0;
      clr_p_reg <= 3'h0;
    end else begin
      clr_a_reg <= (clr_req && s_axi_wdata[0]) ? 3'h7 : clr_a_reg - {2'h0, clr_a_reg != 3'h0};
      clr_p_reg <= (clr_req && s_axi_wdata[1]) ? 3'h7 : clr_p_reg - {2'h0, clr_p_reg != 3'h0};
    end
  end
  a_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_b_single:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("extra write response");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid) else $error("read data late");
  a_r_single:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("extra read data");
  a_bad_read:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h020 |-> ##2
      (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)) else $error("unmapped read not refused");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits not zero");
  a_a_flag_clear:
    assert property ($fell(a_match_flag) |-> clr_a_reg != 3'h0) else $error("A flag lost");
  a_p_flag_clear:
    assert property ($fell(p_match_flag) |-> clr_p_reg != 3'h0) else $error("P flag lost");
  c_a_rise: cover property ($rose(a_match_flag));
  c_p_rise: cover property ($rose(p_match_flag));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_oe_rise: cover property ($rose(timer_output_pin_oe));
endmodule // ptm_periodic_timer_asserts

// [ptm_periodic_timer_tb.sv]
// Self-checking bench for the periodic timer.
`timescale 1ns/1ns
module ptm_periodic_timer_tb;
  reg         clk_sys = 1'b0;
  reg         srst = 1'b1;
  reg  [11:0] s_axi_awaddr = 12'h0;
  reg         s_axi_awvalid = 1'b0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_wvalid = 1'b0;
  reg         s_axi_bready = 1'b0;
  reg  [11:0] s_axi_araddr = 12'h0;
  reg         s_axi_arvalid = 1'b0;
  reg         s_axi_rready = 1'b0;
  reg         ext_clock_trigger_pin = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        timer_output_pin, timer_output_pin_oe, a_match_flag, p_match_flag;
  integer     err_total = 0, total_checks = 0, cyc = 0, i, n;
  reg  [31:0] rd_q;
  reg  [1:0]  resp_q, bresp_q;
  // Rows: address, write byte, read-back byte, read response.
  reg  [29:0] reg_row [0:4] = '{{12'h000, 8'ha5, 8'ha5, 2'h0}, {12'h004, 8'hff, 8'h03, 2'h0},
    {12'h008, 8'h5a, 8'h5a, 2'h0}, {12'h00c, 8'hff, 8'h03, 2'h0}, {12'h040, 8'hff, 8'h00, 2'h2}};
  // Rows: control one, duty, period, window, expected high cycles.
  reg  [49:0] pwm_row [0:5] = '{{8'ha8, 10'h002, 10'h005, 11'h032, 11'h014},
    {8'ha8, 10'h007, 10'h005, 11'h032, 11'h032}, {8'hac, 10'h002, 10'h005, 11'h032, 11'h01e},
    {8'h98, 10'h002, 10'h005, 11'h032, 11'h032}, {8'h88, 10'h002, 10'h005, 11'h032, 11'h000},
    {8'ha8, 10'h200, 10'h000, 11'h400, 11'h200}};
  ptm_periodic_timer i_dut (.clk_sys, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_clock_trigger_pin, .timer_output_pin,
    .timer_output_pin_oe, .a_match_flag, .p_match_flag);
  always #10 clk_sys = ~clk_sys;
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bresp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [11:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Stops the timer and clears both flags before loading a new setup.
  task cfg(input [7:0] c1, input [9:0] a, input [9:0] p);
    wr(12'h010, 8'h00);
    wr(12'h020, 8'h03);
    wr(12'h014, c1);
    wr(12'h000, a[7:0]);
    wr(12'h004, {6'h0, a[9:8]});
    wr(12'h008, p[7:0]);
    wr(12'h00c, {6'h0, p[9:8]});
  endtask
  task wt(input v, input integer lim);
    n = 0;
    while (timer_output_pin !== v && n < lim) begin
      @(posedge clk_sys);
      n = n + 1;
    end
    chk("pin", timer_output_pin, v);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rd(reg_row[i][29:18]);
      chk("reset", rd_q, 32'h0);
    end
    $display("test reset done");
    for (i = 0; i < 5; i = i + 1) begin
      wr(reg_row[i][29:18], reg_row[i][17:10]);
      rd(reg_row[i][29:18]);
      chk("readback", rd_q, {24'h0, reg_row[i][9:2]});
      chk("rresp", resp_q, reg_row[i][1:0]);
      chk("bresp", bresp_q, reg_row[i][1:0]);
    end
    $display("test registers done");
    for (i = 0; i < 6; i = i + 1) begin
      cfg(pwm_row[i][49:42], pwm_row[i][41:32], pwm_row[i][31:22]);
      wr(12'h010, 8'h18);
      repeat (20) @(posedge clk_sys);
      n = 0;
      repeat (pwm_row[i][21:11]) begin
        @(posedge clk_sys);
        n = n + timer_output_pin;
      end
      chk("high cycles", n, pwm_row[i][10:0]);
      chk("pwm p flag", p_match_flag, 1'b1);
    end
    $display("test pwm done");
    cfg(8'h30, 10'h003, 10'h006);
    wr(12'h010, 8'h18);
    // The pin still shows the last run's level until the start reloads it.
    wt(1'b0, 10);
    wt(1'b1, 40);
    chk("a flag", a_match_flag, 1'b1);
    repeat (10) @(posedge clk_sys);
    chk("p flag", p_match_flag, 1'b1);
    chk("oe", timer_output_pin_oe, 1'b1);
    cfg(8'h08, 10'h003, 10'h006);
    wr(12'h010, 8'h18);
    repeat (30) @(posedge clk_sys);
    chk("initial level", timer_output_pin, 1'b1);
    chk("a flag", a_match_flag, 1'b1);
    cfg(8'h31, 10'h005, 10'h002);
    wr(12'h010, 8'h18);
    repeat (40) @(posedge clk_sys);
    chk("a flag", a_match_flag, 1'b1);
    chk("p flag", p_match_flag, 1'b0);
    $display("test compare done");
    cfg(8'hc0, 10'h000, 10'h000);
    wr(12'h010, 8'h18);
    repeat (1100) @(posedge clk_sys);
    chk("a flag", a_match_flag, 1'b0);
    chk("oe", timer_output_pin_oe, 1'b0);
    chk("p flag", p_match_flag, 1'b1);
    wr(12'h010, 8'h98);
    rd(12'h018);
    n = rd_q;
    repeat (8) @(posedge clk_sys);
    rd(12'h018);
    chk("paused count", rd_q, n);
    $display("test timer counter done");
    cfg(8'hb8, 10'h00a, 10'h000);
    wr(12'h010, 8'h18);
    wt(1'b1, 10);
    wt(1'b0, 40);
    chk("a flag", a_match_flag, 1'b1);
    rd(12'h010);
    chk("on bit", rd_q, 32'h10);
    wr(12'h010, 8'h60);
    @(posedge clk_sys);
    ext_clock_trigger_pin <= 1'b1;
    wt(1'b1, 20);
    rd(12'h010);
    chk("on bit", rd_q, 32'h68);
    wr(12'h010, 8'h60);
    wt(1'b0, 20);
    $display("test single pulse done");
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk("flags after reset", {a_match_flag, p_match_flag}, 2'h0);
    chk("oe after reset", timer_output_pin_oe, 1'b0);
    rd(12'h000);
    chk("duty after reset", rd_q, 32'h0);
    $display("test second reset done");
    end_of_test;
  end
endmodule // ptm_periodic_timer_tb
bind ptm_periodic_timer ptm_periodic_timer_asserts i_chk (.clk_sys, .srst, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .a_match_flag, .p_match_flag, .timer_output_pin_oe);
